// ### fifo_mem_pkg.sv
// constants and types shared by the block memory fifo and its fabric controller
// Summary of operation
// - normal write: output shows only read data
// - write-through: output copies incoming write data
// - read-before-write: output shows old location contents
// - separate write and read sides, own enables
// - full flags registered on write side
// - empty flags registered on read side
// - full threshold programmable one to depth-1
// - almost thresholds below full; empty fixed zero
// - fifo clear resets both pointers and flags
// - retransmit clear resets read pointer and empty flags only
// - per-port output latch clear, sync or async
// - global clear resets both latches, always async
// - enables low one cycle around async clears
// - live enables: steady clocks before reset changes
// - preload: global clear disabled or released early
// - fifo mode: read/write enables gate reset timing
// - fifo clear and retransmit clear are async
// - sync reset without global clear: no sequencing
package fifo_mem_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int PTR_W = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  typedef enum logic [1:0] {WRITE_NORMAL, WRITE_THROUGH, READ_BEFORE_WRITE} writeMode_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_QUIET, SEQ_HOLD, SEQ_RELEASE} resetSeq_t;

  // register offsets of the controller
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_LEVELS = 8'h04;
  localparam logic [REG_AW-1:0] OFS_WDATA = 8'h08;
  localparam logic [REG_AW-1:0] OFS_RDATA = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_ADDR = 8'h10;
  localparam logic [REG_AW-1:0] OFS_CMD = 8'h14;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h18;
  localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [REG_AW-1:0] OFS_PORTA = 8'h24;

  // control register fields
  localparam int CTRL_FIFO_MODE = 0;
  localparam int CTRL_WMODE_LO = 1;
  localparam int CTRL_OUT_ASYNC = 3;
  // levels register fields
  localparam int LVL_FULL_LO = 0;
  localparam int LVL_ALMOST_FULL_LO = 4;
  localparam int LVL_ALMOST_EMPTY_LO = 8;
  // address register fields
  localparam int ADDR_A_LO = 0;
  localparam int ADDR_B_LO = 8;
  // command bits; bits 0..4 are clears that run through the reset sequence
  localparam int CMD_FIFO_CLEAR = 0;
  localparam int CMD_RETRANSMIT = 1;
  localparam int CMD_CLEAR_A = 2;
  localparam int CMD_CLEAR_B = 3;
  localparam int CMD_CHIP_CLEAR = 4;
  localparam int CMD_POP = 5;
  localparam int CMD_READ_A = 6;
  localparam int NUM_CLEARS = 5;
  // status / interrupt bits
  localparam int ST_FULL = 0;
  localparam int ST_ALMOST_FULL = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_ALMOST_EMPTY = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_BUSY = 5;
  localparam int NUM_IRQ = 5;

  // values after reset
  localparam logic [ADDR_W-1:0] RST_FULL_LEVEL = 4'hf;
  localparam logic [ADDR_W-1:0] RST_ALMOST_FULL_LEVEL = 4'hc;
  localparam logic [ADDR_W-1:0] RST_ALMOST_EMPTY_LEVEL = 4'h3;
  localparam logic [PTR_W-1:0] EMPTY_LEVEL = 5'h00;
  // flag word after reset: almost empty and empty set, so no edge is seen
  localparam logic [3:0] RST_FLAGS = 4'hc;
endpackage : fifo_mem_pkg

// ### fifo_link_if.sv
// link between the block memory fifo and the fabric controller
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if;
  import fifo_mem_pkg::*;
  // write side
  logic [DATA_W-1:0] writeData;
  logic inputSideClockEnable;
  logic writeEnable;
  // read side
  logic [DATA_W-1:0] readData;
  logic outputSideClockEnable;
  logic outputSideEnable;
  logic [DATA_W-1:0] portAData;
  // flags
  logic fullFlag;
  logic almostFullFlag;
  logic emptyFlag;
  logic almostEmptyFlag;
  // configuration
  logic fifoMode;
  writeMode_t writeMode;
  logic outResetAsync;
  logic [ADDR_W-1:0] fullLevel;
  logic [ADDR_W-1:0] almostFullLevel;
  logic [ADDR_W-1:0] almostEmptyLevel;
  logic [ADDR_W-1:0] addrA;
  logic [ADDR_W-1:0] addrB;
  // clears
  logic fifoClear;
  logic retransmitPointerClear;
  logic portAOutputClear;
  logic portBOutputClear;
  logic chipGlobalClearN;

  modport device_end (
    input writeData, inputSideClockEnable, writeEnable, outputSideClockEnable,
    input outputSideEnable, fifoMode, writeMode, outResetAsync, fullLevel,
    input almostFullLevel, almostEmptyLevel, addrA, addrB, fifoClear,
    input retransmitPointerClear, portAOutputClear, portBOutputClear, chipGlobalClearN,
    output readData, portAData, fullFlag, almostFullFlag, emptyFlag, almostEmptyFlag
  );
  modport fabric_end (
    output writeData, inputSideClockEnable, writeEnable, outputSideClockEnable,
    output outputSideEnable, fifoMode, writeMode, outResetAsync, fullLevel,
    output almostFullLevel, almostEmptyLevel, addrA, addrB, fifoClear,
    output retransmitPointerClear, portAOutputClear, portBOutputClear, chipGlobalClearN,
    input readData, portAData, fullFlag, almostFullFlag, emptyFlag, almostEmptyFlag
  );
endinterface : fifo_link_if
`default_nettype wire

// ### embedded_block_memory.sv
// block memory with three port write modes and a flagged fifo mode
`timescale 1ns/1ps
`default_nettype none
module embedded_block_memory (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link to the fabric
  fifo_link_if.device_end link,
  // user side
  output logic [fifo_mem_pkg::PTR_W-1:0] fillLevel
);
  import fifo_mem_pkg::*;

  function automatic logic [PTR_W-1:0] occupancy(input logic [PTR_W-1:0] wp,
                                                 input logic [PTR_W-1:0] rp);
    occupancy = wp - rp;
  endfunction : occupancy

  logic [DATA_W-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W-1:0] count;
  logic [PTR_W-1:0] next_wrPtr;
  logic [PTR_W-1:0] next_rdPtr;
  logic [PTR_W-1:0] next_count;
  logic writeGo;
  logic readGo;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] rdAddr;
  logic rdPtrClear;
  logic aLatchClear;
  logic bLatchClear;

  assign count = occupancy(wrPtr, rdPtr);
  // overflow and underflow attempts in fifo mode are dropped
  assign writeGo = link.inputSideClockEnable & link.writeEnable
                 & (~link.fifoMode | (count < {1'b0, link.fullLevel}));
  assign readGo = link.outputSideClockEnable & link.outputSideEnable
                & (~link.fifoMode | (count != EMPTY_LEVEL));
  assign wrAddr = link.fifoMode ? wrPtr[ADDR_W-1:0] : link.addrA;
  assign rdAddr = link.fifoMode ? rdPtr[ADDR_W-1:0] : link.addrB;
  assign next_wrPtr = (writeGo & link.fifoMode) ? wrPtr + 5'h01 : wrPtr;
  assign next_rdPtr = (readGo & link.fifoMode) ? rdPtr + 5'h01 : rdPtr;
  assign next_count = occupancy(next_wrPtr, next_rdPtr);
  assign rdPtrClear = link.fifoClear | link.retransmitPointerClear;
  assign aLatchClear = ~link.chipGlobalClearN | (link.portAOutputClear & link.outResetAsync);
  assign bLatchClear = ~link.chipGlobalClearN | (link.portBOutputClear & link.outResetAsync);

  always_ff @(posedge sys_clk) begin
    if (writeGo) begin
      mem[wrAddr] <= link.writeData;
    end
  end

  // write pointer
  always_ff @(posedge sys_clk or posedge link.fifoClear) begin
    if (link.fifoClear) begin
      wrPtr <= '0;
    end else if (rst) begin
      wrPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
    end
  end

  // read pointer; retransmit rewinds it while data stays
  always_ff @(posedge sys_clk or posedge rdPtrClear) begin
    if (rdPtrClear) begin
      rdPtr <= '0;
    end else if (rst) begin
      rdPtr <= '0;
    end else begin
      rdPtr <= next_rdPtr;
    end
  end

  // write-side flags
  always_ff @(posedge sys_clk or posedge link.fifoClear) begin
    if (link.fifoClear) begin
      link.fullFlag <= 1'b0;
      link.almostFullFlag <= 1'b0;
    end else if (rst) begin
      link.fullFlag <= 1'b0;
      link.almostFullFlag <= 1'b0;
    end else begin
      link.fullFlag <= next_count >= {1'b0, link.fullLevel};
      link.almostFullFlag <= next_count >= {1'b0, link.almostFullLevel};
    end
  end

  // read-side flags; empty threshold is fixed at zero
  always_ff @(posedge sys_clk or posedge rdPtrClear) begin
    if (rdPtrClear) begin
      link.emptyFlag <= 1'b1;
      link.almostEmptyFlag <= 1'b1;
    end else if (rst) begin
      link.emptyFlag <= 1'b1;
      link.almostEmptyFlag <= 1'b1;
    end else begin
      link.emptyFlag <= next_count == EMPTY_LEVEL;
      link.almostEmptyFlag <= next_count <= {1'b0, link.almostEmptyLevel};
    end
  end

  // port a output latch, used in ram mode
  always_ff @(posedge sys_clk or posedge aLatchClear) begin
    if (aLatchClear) begin
      link.portAData <= '0;
    end else if (rst | link.portAOutputClear) begin
      link.portAData <= '0;
    end else if (link.inputSideClockEnable & ~link.fifoMode) begin
      if (link.writeEnable) begin
        case (link.writeMode)
          WRITE_THROUGH: link.portAData <= link.writeData;
          READ_BEFORE_WRITE: link.portAData <= mem[link.addrA];
          default: link.portAData <= link.portAData;
        endcase
      end else begin
        link.portAData <= mem[link.addrA];
      end
    end
  end

  // port b / fifo read output latch
  always_ff @(posedge sys_clk or posedge bLatchClear) begin
    if (bLatchClear) begin
      link.readData <= '0;
    end else if (rst | link.portBOutputClear) begin
      link.readData <= '0;
    end else if (readGo) begin
      link.readData <= mem[rdAddr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fillLevel <= '0;
    end else begin
      fillLevel <= next_count;
    end
  end
endmodule : embedded_block_memory
`default_nettype wire

// ### fabric_controller.sv
// fabric controller driving the block memory through software registers
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fabric_controller (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [fifo_mem_pkg::REG_AW-1:0] regAddr,
  input wire logic [fifo_mem_pkg::REG_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [fifo_mem_pkg::REG_DW-1:0] regRdata,
  // interrupt
  output logic irq,
  // link to the memory
  fifo_link_if.fabric_end link
);
  import fifo_mem_pkg::*;

  resetSeq_t seqState;
  logic [NUM_CLEARS-1:0] pendingClears;
  logic [NUM_IRQ-1:0] irqStatus;
  logic [NUM_IRQ-1:0] irqMask;
  logic [NUM_IRQ-1:0] events;
  logic [3:0] prevFlags;
  logic [3:0] flags;
  logic wrCtrl;
  logic wrLevels;
  logic wrData;
  logic wrAddrReg;
  logic wrCmd;
  logic idle;
  logic pushRefused;
  logic clearReq;

  assign flags = {link.almostEmptyFlag, link.emptyFlag, link.almostFullFlag, link.fullFlag};
  assign wrCtrl = regWr & (regAddr == OFS_CTRL);
  assign wrLevels = regWr & (regAddr == OFS_LEVELS);
  assign wrData = regWr & (regAddr == OFS_WDATA);
  assign wrAddrReg = regWr & (regAddr == OFS_ADDR);
  assign wrCmd = regWr & (regAddr == OFS_CMD);
  assign idle = seqState == SEQ_IDLE;
  assign clearReq = wrCmd & (regWdata[NUM_CLEARS-1:0] != '0);
  assign pushRefused = wrData & (~idle | (link.fifoMode & link.fullFlag));
  assign events = {pushRefused, flags & ~prevFlags};

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.fifoMode <= 1'b0;
      link.writeMode <= WRITE_NORMAL;
      link.outResetAsync <= 1'b0;
      link.fullLevel <= RST_FULL_LEVEL;
      link.almostFullLevel <= RST_ALMOST_FULL_LEVEL;
      link.almostEmptyLevel <= RST_ALMOST_EMPTY_LEVEL;
      link.addrA <= '0;
      link.addrB <= '0;
    end else begin
      if (wrCtrl) begin
        link.fifoMode <= regWdata[CTRL_FIFO_MODE];
        link.writeMode <= writeMode_t'(regWdata[CTRL_WMODE_LO +: 2]);
        link.outResetAsync <= regWdata[CTRL_OUT_ASYNC];
      end
      if (wrLevels) begin
        link.fullLevel <= regWdata[LVL_FULL_LO +: ADDR_W];
        link.almostFullLevel <= regWdata[LVL_ALMOST_FULL_LO +: ADDR_W];
        link.almostEmptyLevel <= regWdata[LVL_ALMOST_EMPTY_LO +: ADDR_W];
      end
      if (wrAddrReg) begin
        link.addrA <= regWdata[ADDR_A_LO +: ADDR_W];
        link.addrB <= regWdata[ADDR_B_LO +: ADDR_W];
      end
    end
  end

  // clear sequencing: enables quiet a cycle before and after each clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seqState <= SEQ_IDLE;
      pendingClears <= '0;
    end else begin
      case (seqState)
        SEQ_IDLE: begin
          if (clearReq) begin
            pendingClears <= regWdata[NUM_CLEARS-1:0];
            seqState <= SEQ_QUIET;
          end
        end
        SEQ_QUIET: seqState <= SEQ_HOLD;
        SEQ_HOLD: seqState <= SEQ_RELEASE;
        SEQ_RELEASE: begin
          pendingClears <= '0;
          seqState <= SEQ_IDLE;
        end
        default: seqState <= SEQ_IDLE;
      endcase
    end
  end

  // clear lines are asserted only in the hold cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.fifoClear <= 1'b0;
      link.retransmitPointerClear <= 1'b0;
      link.portAOutputClear <= 1'b0;
      link.portBOutputClear <= 1'b0;
      link.chipGlobalClearN <= 1'b1;
    end else begin
      link.fifoClear <= (seqState == SEQ_QUIET) & pendingClears[CMD_FIFO_CLEAR];
      link.retransmitPointerClear <= (seqState == SEQ_QUIET)
                                   & pendingClears[CMD_RETRANSMIT];
      link.portAOutputClear <= (seqState == SEQ_QUIET) & pendingClears[CMD_CLEAR_A];
      link.portBOutputClear <= (seqState == SEQ_QUIET) & pendingClears[CMD_CLEAR_B];
      link.chipGlobalClearN <= ~((seqState == SEQ_QUIET) & pendingClears[CMD_CHIP_CLEAR]);
    end
  end

  // data path strobes, held low outside the idle state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.writeData <= '0;
      link.writeEnable <= 1'b0;
      link.inputSideClockEnable <= 1'b0;
      link.outputSideEnable <= 1'b0;
      link.outputSideClockEnable <= 1'b0;
    end else begin
      if (wrData) begin
        link.writeData <= regWdata[DATA_W-1:0];
      end
      link.writeEnable <= wrData & ~pushRefused;
      // a command that also starts a clear must not raise any enable
      link.inputSideClockEnable <= idle & (wrData & ~pushRefused
                                         | wrCmd & ~clearReq & regWdata[CMD_READ_A]);
      link.outputSideEnable <= idle & wrCmd & ~clearReq & regWdata[CMD_POP];
      link.outputSideClockEnable <= idle & wrCmd & ~clearReq & regWdata[CMD_POP];
    end
  end

  // sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStatus <= '0;
      irqMask <= '0;
      prevFlags <= RST_FLAGS;
      irq <= 1'b0;
    end else begin
      prevFlags <= flags;
      irqStatus <= (irqStatus & ~(regWr && regAddr == OFS_IRQ_STAT
                                  ? regWdata[NUM_IRQ-1:0] : '0)) | events;
      if (regWr && regAddr == OFS_IRQ_MASK) begin
        irqMask <= regWdata[NUM_IRQ-1:0];
      end
      irq <= |(irqStatus & irqMask);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= '0;
      if (regRd) begin
        case (regAddr)
          OFS_CTRL: regRdata <= {28'h0, link.outResetAsync, link.writeMode, link.fifoMode};
          OFS_LEVELS: regRdata <= {20'h0, link.almostEmptyLevel, link.almostFullLevel,
                                   link.fullLevel};
          OFS_WDATA: regRdata <= {24'h0, link.writeData};
          OFS_RDATA: regRdata <= {24'h0, link.readData};
          OFS_ADDR: regRdata <= {20'h0, link.addrB, 4'h0, link.addrA};
          OFS_STATUS: regRdata <= {26'h0, ~idle, 1'b0, flags};
          OFS_IRQ_STAT: regRdata <= {27'h0, irqStatus};
          OFS_IRQ_MASK: regRdata <= {27'h0, irqMask};
          OFS_PORTA: regRdata <= {24'h0, link.portAData};
          default: regRdata <= '0;
        endcase
      end
    end
  end
endmodule : fabric_controller
`default_nettype wire

// ### fifo_link_props.sv
// concurrent checks on the link between the block memory fifo and its controller
`timescale 1ns/1ps
`default_nettype none
module fifo_link_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // write side
  input wire logic [fifo_mem_pkg::DATA_W-1:0] writeData,
  input wire logic inputSideClockEnable,
  input wire logic writeEnable,
  // read side
  input wire logic [fifo_mem_pkg::DATA_W-1:0] readData,
  input wire logic outputSideClockEnable,
  input wire logic outputSideEnable,
  input wire logic [fifo_mem_pkg::DATA_W-1:0] portAData,
  // flags
  input wire logic fullFlag,
  input wire logic almostFullFlag,
  input wire logic emptyFlag,
  input wire logic almostEmptyFlag,
  // configuration
  input wire logic fifoMode,
  input wire fifo_mem_pkg::writeMode_t writeMode,
  input wire logic [fifo_mem_pkg::ADDR_W-1:0] fullLevel,
  input wire logic [fifo_mem_pkg::ADDR_W-1:0] almostFullLevel,
  input wire logic [fifo_mem_pkg::ADDR_W-1:0] almostEmptyLevel,
  // clears
  input wire logic fifoClear,
  input wire logic retransmitPointerClear,
  input wire logic portAOutputClear,
  input wire logic portBOutputClear,
  input wire logic chipGlobalClearN
);
  import fifo_mem_pkg::*;
  logic [PTR_W-1:0] wrCount;
  logic [PTR_W-1:0] rdCount;
  logic [PTR_W-1:0] occ;
  logic push;
  logic pop;
  logic anyEn;
  logic anyClr;
  assign occ = wrCount - rdCount;
  assign push = fifoMode && inputSideClockEnable && writeEnable && (occ < {1'b0, fullLevel});
  assign pop = fifoMode && outputSideClockEnable && outputSideEnable && (occ != '0);
  assign anyEn = inputSideClockEnable | writeEnable | outputSideClockEnable | outputSideEnable;
  assign anyClr = fifoClear | retransmitPointerClear | portAOutputClear | portBOutputClear
    | !chipGlobalClearN;
  // reference occupancy that the flags must follow
  always_ff @(posedge sys_clk) begin
    if (rst || fifoClear) begin
      wrCount <= '0;
    end else if (push) begin
      wrCount <= wrCount + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || fifoClear || retransmitPointerClear) begin
      rdCount <= '0;
    end else if (pop) begin
      rdCount <= rdCount + 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // flags are only comparable once levels and pointers have settled
  sequence seqSteady;
    fifoMode && $past(fifoMode) && !fifoClear && !retransmitPointerClear
      && !$past(retransmitPointerClear) && $stable(fullLevel) && $stable(almostFullLevel)
      && $stable(almostEmptyLevel);
  endsequence
  sequence seqQuiet;
    !anyEn && !$past(anyEn);
  endsequence
  a_full_occupancy: assert property (seqSteady |-> fullFlag == (occ >= {1'b0, fullLevel}))
    else $error("full flag wrong");
  a_afull_occupancy: assert property (seqSteady |-> almostFullFlag == (occ >= {1'b0, almostFullLevel}))
    else $error("almost full flag wrong");
  a_empty_occupancy: assert property (seqSteady |-> emptyFlag == (occ == '0))
    else $error("empty flag wrong");
  a_aempty_occupancy: assert property (seqSteady |-> almostEmptyFlag == (occ <= {1'b0, almostEmptyLevel}))
    else $error("almost empty flag wrong");
  a_clear_flags: assert property (fifoClear |=> emptyFlag && almostEmptyFlag && !fullFlag && !almostFullFlag)
    else $error("flags not reset by fifo clear");
  a_retransmit_empty: assert property (retransmitPointerClear |-> emptyFlag && almostEmptyFlag)
    else $error("retransmit clear did not force empty");
  a_quiet_before: assert property ($rose(anyClr) |-> seqQuiet)
    else $error("enables active around clear start");
  a_quiet_after: assert property ($fell(anyClr) |-> !anyEn)
    else $error("enables active right after clear");
  a_normal_hold: assert property (!fifoMode && writeMode == WRITE_NORMAL && inputSideClockEnable
      && writeEnable |=> $stable(portAData))
    else $error("normal write changed port output");
  a_write_through: assert property (!fifoMode && writeMode == WRITE_THROUGH
      && inputSideClockEnable && writeEnable |=> portAData == $past(writeData))
    else $error("write data not passed through");
  a_pop_empty: assert property (fifoMode && outputSideClockEnable && outputSideEnable
      && occ == '0 |=> $stable(readData))
    else $error("read from empty fifo changed output");
  a_global_clear: assert property (!chipGlobalClearN
      |-> portAData == '0 && readData == '0)
    else $error("global clear left output data");
endmodule : fifo_link_props
`default_nettype wire

// ### tb_block_ram_fifo_with_resets.sv
// testbench: register accesses drive the controller and the block memory it faces
`timescale 1ns/1ps
`default_nettype none
module tb_block_ram_fifo_with_resets;
  import fifo_mem_pkg::*;
  localparam logic [31:0] WD[3] = '{32'h22, 32'h33, 32'h44};
  localparam logic [31:0] PA[3] = '{32'h11, 32'h33, 32'h33};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [REG_AW-1:0] regAddr = '0;
  logic [REG_DW-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [REG_DW-1:0] regRdata;
  logic irq;
  logic [PTR_W-1:0] fillLevel;
  int fails = 0;
  int n_checks = 0;
  fifo_link_if linkBus();
  embedded_block_memory embedded_block_memory_inst (.sys_clk(sys_clk), .rst(rst),
    .link(linkBus), .fillLevel(fillLevel));
  fabric_controller fabric_controller_inst (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
    .link(linkBus));
  fifo_link_props fifo_link_props_inst (.sys_clk(sys_clk), .rst(rst),
    .writeData(linkBus.writeData), .inputSideClockEnable(linkBus.inputSideClockEnable),
    .writeEnable(linkBus.writeEnable), .readData(linkBus.readData),
    .outputSideClockEnable(linkBus.outputSideClockEnable),
    .outputSideEnable(linkBus.outputSideEnable), .portAData(linkBus.portAData),
    .fullFlag(linkBus.fullFlag), .almostFullFlag(linkBus.almostFullFlag),
    .emptyFlag(linkBus.emptyFlag), .almostEmptyFlag(linkBus.almostEmptyFlag),
    .fifoMode(linkBus.fifoMode), .writeMode(linkBus.writeMode), .fullLevel(linkBus.fullLevel),
    .almostFullLevel(linkBus.almostFullLevel), .almostEmptyLevel(linkBus.almostEmptyLevel),
    .fifoClear(linkBus.fifoClear), .retransmitPointerClear(linkBus.retransmitPointerClear),
    .portAOutputClear(linkBus.portAOutputClear), .portBOutputClear(linkBus.portBOutputClear),
    .chipGlobalClearN(linkBus.chipGlobalClearN));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [REG_AW-1:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata & mask, exp);
  endtask : rdchk
  // command, then let any clear sequence run out
  task automatic cmd(input int bitNo);
    wr(OFS_CMD, 32'h1 << bitNo);
    repeat (5) @(posedge sys_clk);
  endtask : cmd
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irqchk
  // status flags for levels full 15, almost full 14, almost empty 1
  function automatic logic [31:0] expst(input int occ);
    return {28'h0, occ <= 1, occ == 0, occ >= 14, occ >= 15};
  endfunction : expst
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(OFS_STATUS, 32'h3f, 32'h0c);
    rdchk(OFS_LEVELS, 32'hfff, 32'h3cf);
    rdchk(8'h3c, 32'hffffffff, 32'h0);
    rdchk(OFS_IRQ_STAT, 32'h1f, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_LEVELS, 32'h1ef);
    wr(OFS_IRQ_MASK, 32'h10);
    for (int i = 0; i < 16; i++) begin
      wr(OFS_WDATA, 32'h40 + i);
      rdchk(OFS_STATUS, 32'h0f, expst(i < 15 ? i + 1 : 15));
    end
    chk({27'h0, fillLevel}, 32'd15);
    rdchk(OFS_IRQ_STAT, 32'h10, 32'h10);
    irqchk(1'b1);
    wr(OFS_IRQ_MASK, 32'h0);
    irqchk(1'b0);
    wr(OFS_IRQ_MASK, 32'h10);
    irqchk(1'b1);
    wr(OFS_IRQ_STAT, 32'h1f);
    irqchk(1'b0);
    for (int k = 0; k < 15; k++) begin
      cmd(CMD_POP);
      rdchk(OFS_RDATA, 32'hff, 32'h40 + k);
      rdchk(OFS_STATUS, 32'h0f, expst(14 - k));
    end
    cmd(CMD_POP);
    rdchk(OFS_RDATA, 32'hff, 32'h4e);
    cmd(CMD_RETRANSMIT);
    cmd(CMD_POP);
    rdchk(OFS_RDATA, 32'hff, 32'h40);
    rdchk(OFS_STATUS, 32'h0f, expst(14));
    cmd(CMD_FIFO_CLEAR);
    rdchk(OFS_STATUS, 32'h0f, expst(0));
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ADDR, 32'h0505);
    wr(OFS_WDATA, 32'h11);
    cmd(CMD_READ_A);
    rdchk(OFS_PORTA, 32'hff, 32'h11);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL, m << 1);
      wr(OFS_WDATA, WD[m]);
      rdchk(OFS_PORTA, 32'hff, PA[m]);
    end
    cmd(CMD_POP);
    rdchk(OFS_RDATA, 32'hff, 32'h44);
    cmd(CMD_CLEAR_A);
    cmd(CMD_CLEAR_B);
    rdchk(OFS_PORTA, 32'hff, 32'h0);
    rdchk(OFS_RDATA, 32'hff, 32'h0);
    // port clears acting asynchronously
    wr(OFS_CTRL, 32'h8);
    cmd(CMD_READ_A);
    cmd(CMD_POP);
    cmd(CMD_CLEAR_B);
    rdchk(OFS_RDATA, 32'hff, 32'h0);
    rdchk(OFS_PORTA, 32'hff, 32'h44);
    cmd(CMD_CLEAR_A);
    rdchk(OFS_PORTA, 32'hff, 32'h0);
    cmd(CMD_READ_A);
    cmd(CMD_POP);
    cmd(CMD_CHIP_CLEAR);
    rdchk(OFS_PORTA, 32'hff, 32'h0);
    rdchk(OFS_RDATA, 32'hff, 32'h0);
    print_verdict();
  end
endmodule : tb_block_ram_fifo_with_resets
`default_nettype wire
